// >>> hdl/spi_fetch_pkg.sv
// Constants and enumerations for the serial flash code-fetch controller.
// Assumes a flash that answers fast read and dual fast read in serial mode 0.
`default_nettype none

package spi_fetch_pkg;

    // ------------------------------------------------------------
    // Command encoding
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_FAST     = 8'h0B;
    localparam logic [7:0]  OP_DUAL     = 8'h3B;
    localparam logic [7:0]  DUMMY_BYTE  = 8'h00;

    // ------------------------------------------------------------
    // Boot check
    // ------------------------------------------------------------
    localparam logic [23:0] BOOT_ADDR   = 24'h00FFFA;
    localparam logic [23:0] EXEC_ADDR   = 24'h000000;
    // Bytes read back in this order: "2", "D", "F", "U"
    localparam logic [31:0] SIGNATURE   = 32'h3244_4655;
    localparam logic [2:0]  SIG_LEN     = 3'h4;

    // ------------------------------------------------------------
    // Serial framing, counted in serial clocks
    // ------------------------------------------------------------
    // Opcode, three address bytes and the dummy byte: 40 bits
    localparam logic [5:0]  HDR_LAST    = 6'h27;
    localparam logic [6:0]  HDR_CLKS    = 7'h28;
    localparam logic [5:0]  LAST_SINGLE = 6'h07;
    localparam logic [5:0]  LAST_DUAL   = 6'h03;
    localparam logic [3:0]  CLKS_SINGLE = 4'h8;
    localparam logic [3:0]  CLKS_DUAL   = 4'h4;

    // System clocks after reset release before the strap is taken
    localparam logic [1:0]  STRAP_WAIT  = 2'h3;

    localparam int          FIFO_WIDTH  = 8;
    localparam int          FIFO_DEPTH  = 4;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {K_START, K_NEXT, K_STOP} kind_e;
    typedef enum logic [2:0] {L_IDLE, L_TX, L_RX, L_WAIT, L_HOLD} lstate_e;
    typedef enum logic [1:0] {S_STRAP, S_SIG, S_END, S_RUN} sstate_e;

endpackage

`default_nettype wire

// >>> hdl/spi_flash_code_fetch.sv
// Code-fetch controller serving processor byte reads from a serial flash.
// Assumes clk_link is a free-running clock; the serial clock is half its rate.
//
// Overview of operation
// - Code read: chip select low, send opcode 0x0B and 24-bit address.
// - One dummy byte follows the address before any data is captured.
// - Single mode: eight serial clocks after the dummy carry one data byte.
// - A complete byte raises ready; the processor takes exactly that byte.
// - Sequential next address keeps chip select low and fetches one more byte.
// - Any other next address ends the transaction, chip select high.
// - Dual read is optional and only allowed at the 30 MHz link speed.
// - Dual mode: chip select low, opcode 0x3B, 24-bit address, dummy byte.
// - Dual mode: four clocks per byte, two bits on both data lines.
// - Strap on flash data-out: low picks 30 MHz, high picks 60 MHz.
// - Strap is taken once after reset release and then held.
// - At power-up read flash from 0xFFFA and check the 2DFU signature.
// - Valid signature enables flash, start at 0x0000, else internal ROM.
`default_nettype none

// ------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------
module fetch_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_s;

    fifo_s fifo;
    fifo_s next_fifo;
    logic  push;
    logic  pop;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = fifo.cnt != (AW + 1)'(DEPTH);
    assign out_valid = fifo.cnt != '0;
    assign out_data  = fifo.mem[fifo.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_fifo = fifo;
        if (push) begin
            next_fifo.mem[fifo.wp] = in_data;
            next_fifo.wp = inc(fifo.wp);
        end
        if (pop) begin
            next_fifo.rp = inc(fifo.rp);
        end
        next_fifo.cnt = fifo.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo <= '0;
        end else begin
            fifo <= next_fifo;
        end
    end
endmodule

// ------------------------------------------------------------
// Controller top
// ------------------------------------------------------------
module spi_flash_code_fetch #(
    parameter int FIFO_DEPTH = spi_fetch_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_link,
    input  wire logic        fetch_valid,
    input  wire logic [23:0] fetch_addr,
    output logic             fetch_ready,
    output logic [7:0]       fetch_data,
    input  wire logic        dual_enable,
    output logic             boot_done,
    output logic             boot_ext,
    output logic [23:0]      exec_start_addr,
    output logic             link_speed_60,
    output logic             flash_cs_n,
    output logic             flash_sck,
    output logic             flash_do_out,
    output logic             flash_do_oe,
    input  wire logic        flash_do_in,
    input  wire logic        flash_di_in
);
    typedef struct packed {
        spi_fetch_pkg::lstate_e st;
        logic        sck;
        logic        cs_n;
        logic        mosi;
        logic        oe;
        logic        dual;
        logic        strb;
        logic        strb2;
        logic        rq1;
        logic        rq2;
        logic        rq_seen;
        logic        ack;
        logic [1:0]  io1;
        logic [1:0]  io2;
        logic [39:0] sh;
        logic [5:0]  cnt;
        logic [7:0]  rx;
        logic [7:0]  rdata;
    } link_s;

    typedef struct packed {
        spi_fetch_pkg::sstate_e st;
        spi_fetch_pkg::kind_e   kind;
        logic [1:0]  scnt;
        logic [1:0]  ds;
        logic [2:0]  ak;
        logic        speed60;
        logic        done;
        logic        ext;
        logic        open;
        logic        busy;
        logic        outst;
        logic        req;
        logic        dual;
        logic        sig_ok;
        logic        push;
        logic [2:0]  sidx;
        logic [7:0]  pdata;
        logic [23:0] addr;
        logic [23:0] last;
        logic [23:0] start;
    } sys_s;

    link_s      link;
    link_s      next_link;
    sys_s       sys;
    sys_s       next_sys;
    logic [1:0] lrst;
    logic       rst_link;
    logic       ack_evt;
    logic       f_in_ready;
    logic       f_out_valid;
    logic       f_out_ready;
    logic [7:0] f_out_data;
    logic       pop;

    function automatic logic [7:0] sig_byte(input logic [2:0] i);
        logic [31:0] t;
        t = spi_fetch_pkg::SIGNATURE << {i[1:0], 3'b000};
        return t[31:24];
    endfunction

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    // Reset asserts at once and releases on the link clock
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            lrst <= 2'b11;
        end else begin
            lrst <= {lrst[0], 1'b0};
        end
    end
    assign rst_link = lrst[1];

    always_comb begin
        next_link = link;
        next_link.rq1 = sys.req;
        next_link.rq2 = link.rq1;
        next_link.io1 = {flash_di_in, flash_do_in};
        next_link.io2 = link.io1;
        next_link.strb = 1'b0;
        next_link.strb2 = link.strb;
        // Pins pass two flops, so data bits land two clocks after their strobe
        if (link.strb2) begin
            next_link.rx = link.dual ? {link.rx[5:0], link.io2} : {link.rx[6:0], link.io2[1]};
        end
        case (link.st)
            spi_fetch_pkg::L_IDLE, spi_fetch_pkg::L_HOLD: begin
                if (link.rq2 != link.rq_seen) begin
                    next_link.rq_seen = link.rq2;
                    case (sys.kind)
                        spi_fetch_pkg::K_STOP: begin
                            next_link.cs_n = 1'b1;
                            next_link.oe = 1'b0;
                            next_link.ack = ~link.ack;
                            next_link.st = spi_fetch_pkg::L_IDLE;
                        end
                        spi_fetch_pkg::K_START: begin
                            next_link.cs_n = 1'b0;
                            next_link.oe = 1'b1;
                            next_link.dual = sys.dual;
                            next_link.sh = {sys.dual ? spi_fetch_pkg::OP_DUAL : spi_fetch_pkg::OP_FAST,
                                            sys.addr, spi_fetch_pkg::DUMMY_BYTE};
                            next_link.mosi = next_link.sh[39];
                            next_link.cnt = spi_fetch_pkg::HDR_LAST;
                            next_link.st = spi_fetch_pkg::L_TX;
                        end
                        default: begin
                            next_link.cnt = link.dual ? spi_fetch_pkg::LAST_DUAL : spi_fetch_pkg::LAST_SINGLE;
                            next_link.st = spi_fetch_pkg::L_RX;
                        end
                    endcase
                end
            end
            spi_fetch_pkg::L_TX: begin
                next_link.sck = ~link.sck;
                // Outgoing bits change with the falling edge, MSB first
                if (link.sck) begin
                    if (link.cnt == '0) begin
                        next_link.cnt = link.dual ? spi_fetch_pkg::LAST_DUAL : spi_fetch_pkg::LAST_SINGLE;
                        next_link.oe = ~link.dual;
                        next_link.mosi = 1'b0;
                        next_link.st = spi_fetch_pkg::L_RX;
                    end else begin
                        next_link.sh = {link.sh[38:0], 1'b0};
                        next_link.mosi = link.sh[38];
                        next_link.cnt = link.cnt - 1'b1;
                    end
                end
            end
            spi_fetch_pkg::L_RX: begin
                next_link.sck = ~link.sck;
                if (!link.sck) begin
                    next_link.strb = 1'b1;
                end else if (link.cnt == '0) begin
                    next_link.st = spi_fetch_pkg::L_WAIT;
                end else begin
                    next_link.cnt = link.cnt - 1'b1;
                end
            end
            spi_fetch_pkg::L_WAIT: begin
                if (!link.strb && !link.strb2) begin
                    next_link.rdata = link.rx;
                    next_link.ack = ~link.ack;
                    next_link.st = spi_fetch_pkg::L_HOLD;
                end
            end
            default: begin
                next_link.st = spi_fetch_pkg::L_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            link <= '0;
            link.cs_n <= 1'b1;
        end else begin
            link <= next_link;
        end
    end

    assign flash_cs_n   = link.cs_n;
    assign flash_sck    = link.sck;
    assign flash_do_out = link.mosi;
    assign flash_do_oe  = link.oe;

    // ------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------
    assign ack_evt     = sys.ak[2] ^ sys.ak[1];
    assign f_out_ready = (sys.st == spi_fetch_pkg::S_SIG) | (sys.st == spi_fetch_pkg::S_RUN & sys.ext & fetch_valid);
    assign pop         = f_out_valid & f_out_ready;
    assign fetch_ready = (sys.st == spi_fetch_pkg::S_RUN) & sys.ext & f_out_valid;
    assign fetch_data  = f_out_data;

    always_comb begin
        logic go;
        go = 1'b0;
        next_sys = sys;
        next_sys.ak = {sys.ak[1:0], link.ack};
        next_sys.ds = {sys.ds[0], flash_do_in};
        if (sys.push && f_in_ready) begin
            next_sys.push = 1'b0;
        end
        // Read data is held by the link until the next request
        if (ack_evt) begin
            next_sys.busy = 1'b0;
            if (sys.kind != spi_fetch_pkg::K_STOP) begin
                next_sys.push = 1'b1;
                next_sys.pdata = link.rdata;
            end
        end
        if (pop) begin
            next_sys.outst = 1'b0;
        end
        case (sys.st)
            spi_fetch_pkg::S_STRAP: begin
                next_sys.scnt = sys.scnt + 1'b1;
                if (sys.scnt == spi_fetch_pkg::STRAP_WAIT) begin
                    next_sys.speed60 = sys.ds[1];
                    next_sys.sig_ok = 1'b1;
                    next_sys.st = spi_fetch_pkg::S_SIG;
                end
            end
            spi_fetch_pkg::S_SIG: begin
                if (pop) begin
                    next_sys.sig_ok = sys.sig_ok & (f_out_data == sig_byte(sys.sidx));
                    next_sys.sidx = sys.sidx + 1'b1;
                end
                if (!sys.busy && !sys.outst && !sys.push) begin
                    go = 1'b1;
                    if (sys.sidx == spi_fetch_pkg::SIG_LEN) begin
                        next_sys.kind = spi_fetch_pkg::K_STOP;
                        next_sys.st = spi_fetch_pkg::S_END;
                    end else begin
                        next_sys.kind = (sys.sidx == '0) ? spi_fetch_pkg::K_START : spi_fetch_pkg::K_NEXT;
                        next_sys.addr = spi_fetch_pkg::BOOT_ADDR;
                        next_sys.dual = 1'b0;
                        next_sys.outst = 1'b1;
                    end
                end
            end
            spi_fetch_pkg::S_END: begin
                if (!sys.busy) begin
                    next_sys.done = 1'b1;
                    next_sys.ext = sys.sig_ok;
                    next_sys.start = spi_fetch_pkg::EXEC_ADDR;
                    next_sys.st = spi_fetch_pkg::S_RUN;
                end
            end
            spi_fetch_pkg::S_RUN: begin
                // Internal ROM boot leaves the flash port idle for good
                if (sys.ext && fetch_valid && !sys.busy && !sys.outst && !sys.push) begin
                    go = 1'b1;
                    if (sys.open && fetch_addr == sys.last + 24'h1) begin
                        next_sys.kind = spi_fetch_pkg::K_NEXT;
                        next_sys.last = fetch_addr;
                        next_sys.outst = 1'b1;
                    end else if (sys.open) begin
                        next_sys.kind = spi_fetch_pkg::K_STOP;
                        next_sys.open = 1'b0;
                    end else begin
                        next_sys.kind = spi_fetch_pkg::K_START;
                        next_sys.addr = fetch_addr;
                        next_sys.dual = dual_enable & ~sys.speed60;
                        next_sys.open = 1'b1;
                        next_sys.last = fetch_addr;
                        next_sys.outst = 1'b1;
                    end
                end
            end
            default: begin
                next_sys.st = spi_fetch_pkg::S_STRAP;
            end
        endcase
        if (go) begin
            next_sys.req = ~sys.req;
            next_sys.busy = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sys <= '0;
        end else begin
            sys <= next_sys;
        end
    end

    assign boot_done       = sys.done;
    assign boot_ext        = sys.ext;
    assign exec_start_addr = sys.start;
    assign link_speed_60   = sys.speed60;

    fetch_fifo #(
        .WIDTH (spi_fetch_pkg::FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk_sys),
        .rst       (rst),
        .in_valid  (sys.push),
        .in_ready  (f_in_ready),
        .in_data   (sys.pdata),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic       sck_d;
    logic [6:0] hr;
    logic [3:0] br;

    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            sck_d <= 1'b0;
            hr <= '0;
            br <= '0;
        end else begin
            sck_d <= link.sck;
            if (link.cs_n) begin
                hr <= '0;
            end else if (link.sck && !sck_d && hr != 7'h7F) begin
                hr <= hr + 1'b1;
            end
            if (link.st != spi_fetch_pkg::L_RX && link.st != spi_fetch_pkg::L_WAIT) begin
                br <= '0;
            end else if (link.sck && !sck_d) begin
                br <= br + 1'b1;
            end
        end
    end

    a_sck_cs_low: assert property (@(posedge clk_link) disable iff (rst_link)
        flash_sck |-> !flash_cs_n) else $error("serial clock high with chip select high");
    a_opcode_fast: assert property (@(posedge clk_link) disable iff (rst_link)
        (link.st == spi_fetch_pkg::L_TX && $past(link.st) != spi_fetch_pkg::L_TX && !link.dual)
        |-> link.sh[39:32] == spi_fetch_pkg::OP_FAST && !flash_cs_n) else $error("wrong fast read opcode");
    a_opcode_dual: assert property (@(posedge clk_link) disable iff (rst_link)
        (link.st == spi_fetch_pkg::L_TX && $past(link.st) != spi_fetch_pkg::L_TX && link.dual)
        |-> link.sh[39:32] == spi_fetch_pkg::OP_DUAL) else $error("wrong dual read opcode");
    a_dummy_first: assert property (@(posedge clk_link) disable iff (rst_link)
        (link.st == spi_fetch_pkg::L_RX && link.sck && !sck_d) |-> hr >= spi_fetch_pkg::HDR_CLKS)
        else $error("data captured before header and dummy done");
    a_byte_single: assert property (@(posedge clk_link) disable iff (rst_link)
        (link.st == spi_fetch_pkg::L_WAIT && !link.dual) |-> br == spi_fetch_pkg::CLKS_SINGLE)
        else $error("single byte not eight clocks");
    a_byte_dual: assert property (@(posedge clk_link) disable iff (rst_link)
        (link.st == spi_fetch_pkg::L_WAIT && link.dual) |-> br == spi_fetch_pkg::CLKS_DUAL)
        else $error("dual byte not four clocks");
    a_dual_release: assert property (@(posedge clk_link) disable iff (rst_link)
        (link.st == spi_fetch_pkg::L_RX && link.dual) |-> !flash_do_oe) else $error("data-out driven in dual read");
    a_speed_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (sys.st != spi_fetch_pkg::S_STRAP && $past(sys.st) != spi_fetch_pkg::S_STRAP) |-> $stable(sys.speed60))
        else $error("speed strap changed");
    a_dual_slow: assert property (@(posedge clk_sys) disable iff (rst)
        sys.dual |-> !sys.speed60) else $error("dual read at fast speed");
    a_boot_addr: assert property (@(posedge clk_sys) disable iff (rst)
        (sys.st == spi_fetch_pkg::S_SIG && $changed(sys.req) && sys.kind == spi_fetch_pkg::K_START)
        |-> sys.addr == spi_fetch_pkg::BOOT_ADDR) else $error("boot read not at signature address");
    a_boot_exit: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(sys.done) |-> sys.start == spi_fetch_pkg::EXEC_ADDR && sys.ext == sys.sig_ok)
        else $error("boot decision wrong");
    a_seq_next: assert property (@(posedge clk_sys) disable iff (rst)
        (sys.st == spi_fetch_pkg::S_RUN && $changed(sys.req) && $past(sys.open)
         && $past(fetch_addr) == $past(sys.last) + 24'h1) |-> sys.kind == spi_fetch_pkg::K_NEXT)
        else $error("sequential fetch did not continue");
    a_jump_stop: assert property (@(posedge clk_sys) disable iff (rst)
        (sys.st == spi_fetch_pkg::S_RUN && $changed(sys.req) && $past(sys.open)
         && $past(fetch_addr) != $past(sys.last) + 24'h1) |-> sys.kind == spi_fetch_pkg::K_STOP)
        else $error("jump did not end transaction");
    a_ready_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(fetch_ready) |-> $past(sys.push) && sys.outst) else $error("ready without captured byte");

endmodule

`default_nettype wire

// >>> verification/flash_model.sv
// Serial flash model answering fast and dual fast read in mode 0.
// Assumes the controller alone drives chip select, clock and data-out.
`default_nettype none
module flash_model (
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic oe,
    input  wire logic strap,
    input  wire logic sig_ok,
    output logic      miso = 1'b0,
    output logic      io0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] hdr;
    logic [23:0] a;
    logic [7:0]  sh;
    logic [7:0]  op;
    int          n = 0;
    int          bc = 0;
    logic        drv = 1'b0;
    logic        d0 = 1'b0;
    function automatic logic [7:0] mem(input logic [23:0] ad);
        if (sig_ok && ad >= 24'hFFFA && ad <= 24'hFFFD)
            return spi_fetch_pkg::SIGNATURE[31 - 8 * int'(ad - 24'hFFFA) -: 8];
        return ad[7:0] ^ 8'h5A;
    endfunction
    // Pull level shows whenever nobody drives the pin
    assign io0 = oe ? mosi : (drv ? d0 : strap);
    // One process owns every model variable; the levels tell the edges apart
    always @(posedge sck or negedge sck or posedge cs_n) begin
        if (cs_n) begin
            n = 0;
            bc = 0;
            drv = 1'b0;
            miso = ~miso; // Released line must not keep its last bit
        end else if (sck) begin
            if (n < 40) begin
                hdr = {hdr[38:0], mosi};
                n++;
                op = hdr[39:32];
                if (n == 40)
                    a = hdr[31:8];
            end
        end else if (n == 40) begin
            if (bc == 0) begin
                sh = mem(a);
                a++;
            end
            miso = sh[7];
            d0 = sh[6];
            drv = (op == spi_fetch_pkg::OP_DUAL);
            sh = drv ? sh << 2 : sh << 1;
            bc = (bc + 1) % (drv ? 4 : 8);
        end
    end
endmodule
`default_nettype wire

// >>> verification/spi_flash_code_fetch_bench.sv
// Self-checking bench for the serial flash code-fetch controller.
// Assumes flash_model on the flash pins; data byte is address low byte xor 5A.
`default_nettype none
module spi_flash_code_fetch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [23:0] a; logic d;} row_s;
    logic        clk_sys = 0, clk_link = 0, rst = 1, fetch_valid = 0;
    logic        dual_enable = 0, strap = 0, sig_ok = 1;
    logic [23:0] fetch_addr = 0;
    logic        fetch_ready, boot_done, boot_ext, link_speed_60, flash_cs_n;
    logic        flash_sck, flash_do_out, flash_do_oe, flash_do_in, flash_di_in;
    logic [7:0]  fetch_data, got;
    logic [23:0] exec_start_addr;
    int          num_errors = 0, n_tests = 0, n_starts = 0;
    row_s        rows [9] = '{'{24'h0, 0}, '{24'h1, 0}, '{24'h2, 0}, '{24'h10, 0},
                    '{24'h10, 0}, '{24'h11, 0}, '{24'h100, 1}, '{24'h101, 1}, '{24'h200, 0}};
    always #5 clk_sys = ~clk_sys;
    always #32 clk_link = ~clk_link;
    always @(negedge flash_cs_n) n_starts++;
    spi_flash_code_fetch dut (.clk_sys, .rst, .clk_link, .fetch_valid, .fetch_addr, .fetch_ready,
        .fetch_data, .dual_enable, .boot_done, .boot_ext, .exec_start_addr, .link_speed_60,
        .flash_cs_n, .flash_sck, .flash_do_out, .flash_do_oe, .flash_do_in, .flash_di_in);
    flash_model flash (.cs_n(flash_cs_n), .sck(flash_sck), .mosi(flash_do_out), .oe(flash_do_oe),
        .strap, .sig_ok, .miso(flash_di_in), .io0(flash_do_in));
    task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t: value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_flag(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic fetch(input logic [23:0] a);
        @(negedge clk_sys);
        fetch_valid = 1;
        fetch_addr = a;
        repeat (3000) begin
            @(negedge clk_sys);
            if (fetch_ready === 1'b1)
                break;
        end
        chk_flag(fetch_ready, 1'b1);
        got = fetch_data;
        @(negedge clk_sys);
        fetch_valid = 0;
    endtask
    task automatic wait_boot;
        repeat (3000)
            if (boot_done !== 1'b1)
                @(negedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run needs about 100 us
    initial begin
        #200_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        chk_flag(flash_cs_n, 1'b1);
        chk_flag(fetch_ready, 1'b0);
        rst = 0;
        wait_boot();
        chk_flag(boot_done, 1'b1);
        chk_flag(boot_ext, 1'b1);
        chk_word(exec_start_addr, 24'h0);
        chk_flag(link_speed_60, 1'b0);
        foreach (rows[i]) begin
            dual_enable = rows[i].d;
            fetch(rows[i].a);
            chk_word({16'h0, got}, {16'h0, rows[i].a[7:0] ^ 8'h5A});
            chk_word({16'h0, flash.op}, rows[i].d ? 24'h3B : 24'h0B);
        end
        // Boot read plus starts at 0, 10, 10 again, 100 and 200
        chk_word(24'(n_starts), 24'h6);
        rst = 1;
        strap = 1;
        sig_ok = 0;
        repeat (20) @(negedge clk_sys);
        chk_flag(boot_done, 1'b0);
        rst = 0;
        wait_boot();
        strap = 0;
        chk_flag(boot_ext, 1'b0);
        fetch_valid = 1;
        repeat (1000) @(negedge clk_sys);
        chk_flag(fetch_ready, 1'b0);
        chk_flag(flash_cs_n, 1'b1);
        chk_flag(link_speed_60, 1'b1);
        // Fast strap with a good image: a dual request must fall back to single
        rst = 1;
        fetch_valid = 0;
        strap = 1;
        sig_ok = 1;
        dual_enable = 1;
        repeat (20) @(negedge clk_sys);
        rst = 0;
        wait_boot();
        chk_flag(boot_ext, 1'b1);
        fetch(24'h300);
        chk_word({16'h0, got}, 24'h00005A);
        chk_word({16'h0, flash.op}, 24'h00000B);
        chk_flag(link_speed_60, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
